// ---- hw/sbb_pkg.sv ----
// Summary of operation
// - Signed pull, zero width: arithmetic right shift by offset, sign fill.
// - Unsigned pull, zero width: logical right shift by offset, zero fill.
// - Insert shift, zero width: left shift by offset, zero fill.
// - Circular shift rotates first source right by offset into destination.
// - Register form rotates by second source bits 4-0; bits 9-5 kept zero.
// - Delayed option executes the next instruction whether or not taken.
// - Delay flag 0 suppresses the next instruction when the branch is taken, 1 executes it.
// - Branch if bit zero taken only when the tested bit is zero.
// - Branch if bit one taken only when the tested bit is one.
// - Target is branch address plus sign-extended displacement times four.
// - Add sums first source with second source or zero-extended immediate.
// - Carry-in option adds the stored carry flag into the sum.
// - Carry-out option writes the new carry unless the add overflows; otherwise the flag holds.
// - Both options add the stored carry and update the flag unless the add overflows.
// - Carry select bits: 0 disables, 1 enables carry in and out.
// - Signed 32-bit add overflow raises an integer overflow exception.
// - Zero register destination writes nothing; carry side effects remain.
// - Width zero means 32 bits; offset is a 5-bit position from bit 0.
package sbb_pkg;
    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_SPULL = 4'h1,
        OP_UPULL = 4'h2,
        OP_INSERT = 4'h3,
        OP_ROT = 4'h4,
        OP_ADD = 4'h5,
        OP_BIT_ZERO = 4'h6,
        OP_BIT_ONE = 4'h7
    } sbb_op_t;

    // Instruction word layout
    typedef struct packed {
        logic [3:0] op;
        logic imm_form;
        logic delay_flag;
        logic [4:0] dest_idx;
        logic [4:0] src1_idx;
        logic [15:0] low;
    } sbb_instr_t;

    typedef struct packed {
        logic valid;
        sbb_instr_t instr;
        logic [31:0] rs1_val;
        logic [31:0] rs2_val;
        logic [31:0] pc;
    } sbb_issue_t;

    typedef struct packed {
        logic valid;
        logic [4:0] idx;
        logic [31:0] data;
        logic ovf;
    } sbb_wb_t;

    typedef struct packed {
        logic valid;
        logic taken;
        logic [31:0] target;
        logic exec_next;
        logic squash_next;
    } sbb_br_t;

    localparam int W_MSB = 9;
    localparam int W_LSB = 5;
    localparam int O_MSB = 4;
    localparam int O_LSB = 0;
    localparam int CIN_BIT = 9;
    localparam int COUT_BIT = 8;
    localparam int SIGN_BIT = 31;
    localparam int DISP_SHIFT = 2;
    localparam int CTRL_CARRY_BIT = 0;
    localparam logic CARRY_RST = 1'b0;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OVF_CNT = 4'h4;
    localparam logic [3:0] ADDR_TARGET = 4'h8;
    localparam logic [3:0] ADDR_RESULT = 4'hC;
endpackage

// ---- hw/sbb_unit.sv ----
`timescale 1ns/1ps
module sbb_unit (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // Issue from decoder
    input wire sbb_pkg::sbb_issue_t i_issue,
    // Results
    output sbb_pkg::sbb_wb_t o_wb,
    output sbb_pkg::sbb_br_t o_br,
    output logic o_carry,
    // Avalon-MM slave
    input wire logic [3:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest
);

    sbb_pkg::sbb_instr_t ins;
    logic [4:0] wid;
    logic [4:0] off;
    logic [31:0] opb;
    logic cin;
    logic cout_en;
    logic [32:0] sum;
    logic ovf;
    logic is_alu;
    logic is_add;
    logic is_br;
    logic tbit;
    logic taken;
    logic [31:0] target;
    logic [31:0] res;
    logic psr_carry_r;
    logic [15:0] ovf_cnt_r;
    logic [31:0] last_tgt_r;
    logic [31:0] last_res_r;
    logic bus_req;
    logic bus_done;

    // Field pull; width zero means the whole word
    function automatic logic [31:0] sbb_pull(
        input logic [31:0] src,
        input logic [4:0] w,
        input logic [4:0] o,
        input logic sgn
    );
        logic [31:0] sh;
        logic [31:0] msk;
        logic top;
        if (sgn) begin
            sh = 32'($signed(src) >>> o);
        end else begin
            sh = src >> o;
        end
        msk = ~(32'hFFFFFFFF << w);
        top = sh[5'(w - 5'h01)];
        if (w == 5'h00) begin
            return sh;
        end
        return (sgn && top) ? (sh | ~msk) : (sh & msk);
    endfunction

    // Field insert; width zero means the whole word
    function automatic logic [31:0] sbb_make(
        input logic [31:0] src,
        input logic [4:0] w,
        input logic [4:0] o
    );
        logic [31:0] msk;
        msk = ~(32'hFFFFFFFF << w);
        if (w == 5'h00) begin
            return src << o;
        end
        return (src & msk) << o;
    endfunction

    // Decode and datapath
    always_comb begin
        ins = i_issue.instr;
        if (ins.imm_form) begin
            wid = ins.low[sbb_pkg::W_MSB:sbb_pkg::W_LSB];
            off = ins.low[sbb_pkg::O_MSB:sbb_pkg::O_LSB];
        end else begin
            wid = i_issue.rs2_val[sbb_pkg::W_MSB:sbb_pkg::W_LSB];
            off = i_issue.rs2_val[sbb_pkg::O_MSB:sbb_pkg::O_LSB];
        end
        opb = ins.imm_form ? 32'(ins.low) : i_issue.rs2_val;
        cin = !ins.imm_form && ins.low[sbb_pkg::CIN_BIT]
            && psr_carry_r;
        cout_en = !ins.imm_form
            && ins.low[sbb_pkg::COUT_BIT];
        sum = {1'b0, i_issue.rs1_val} + {1'b0, opb} + 33'(cin);
        ovf = (i_issue.rs1_val[sbb_pkg::SIGN_BIT] == opb[sbb_pkg::SIGN_BIT])
            && (sum[sbb_pkg::SIGN_BIT]
            != i_issue.rs1_val[sbb_pkg::SIGN_BIT]);
        tbit = i_issue.rs1_val[ins.dest_idx];
        target = i_issue.pc
            + (32'(signed'(ins.low)) << sbb_pkg::DISP_SHIFT);
        is_alu = 1'b1;
        is_add = 1'b0;
        is_br = 1'b0;
        taken = 1'b0;
        res = '0;
        unique case (sbb_pkg::sbb_op_t'(ins.op))
            sbb_pkg::OP_SPULL: begin
                res = sbb_pull(i_issue.rs1_val, wid, off, 1'b1);
            end
            sbb_pkg::OP_UPULL: begin
                res = sbb_pull(i_issue.rs1_val, wid, off, 1'b0);
            end
            sbb_pkg::OP_INSERT: begin
                res = sbb_make(i_issue.rs1_val, wid, off);
            end
            sbb_pkg::OP_ROT: begin
                res = 32'({i_issue.rs1_val, i_issue.rs1_val} >> off);
            end
            sbb_pkg::OP_ADD: begin
                res = sum[31:0];
                is_add = 1'b1;
            end
            sbb_pkg::OP_BIT_ZERO: begin
                is_alu = 1'b0;
                is_br = 1'b1;
                taken = !tbit;
            end
            sbb_pkg::OP_BIT_ONE: begin
                is_alu = 1'b0;
                is_br = 1'b1;
                taken = tbit;
            end
            default: begin
                is_alu = 1'b0;
            end
        endcase
    end

    // Write-back; an overflowing add writes nothing
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_wb <= '0;
        end else begin
            o_wb.valid <= i_issue.valid && is_alu && !(is_add && ovf)
                && (ins.dest_idx != 5'h00);
            o_wb.idx <= ins.dest_idx;
            o_wb.data <= res;
            o_wb.ovf <= i_issue.valid && is_add && ovf;
        end
    end

    // Branch outcome to the fetch sequencer
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_br <= '0;
        end else begin
            o_br.valid <= i_issue.valid && is_br;
            o_br.taken <= i_issue.valid && is_br && taken;
            o_br.target <= target;
            o_br.exec_next <= i_issue.valid && is_br
                && ins.delay_flag;
            o_br.squash_next <= i_issue.valid && is_br && taken
                && !ins.delay_flag;
        end
    end

    // Carry flag of the processor state; an add beats a bus write
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            psr_carry_r <= sbb_pkg::CARRY_RST;
        end else if (i_issue.valid && is_add && cout_en && !ovf) begin
            psr_carry_r <= sum[32];
        end else if (bus_done && i_avs_write
            && i_avs_address == sbb_pkg::ADDR_CTRL && i_avs_byteenable[0]) begin
            psr_carry_r <= i_avs_writedata[sbb_pkg::CTRL_CARRY_BIT];
        end
    end

    assign o_carry = psr_carry_r;

    // Observation registers: overflow counter, last taken target, last written result
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            ovf_cnt_r <= '0;
            last_tgt_r <= '0;
            last_res_r <= '0;
        end else begin
            if (o_wb.ovf) begin
                ovf_cnt_r <= ovf_cnt_r + 16'h0001;
            end
            if (o_br.taken) begin
                last_tgt_r <= o_br.target;
            end
            if (o_wb.valid) begin
                last_res_r <= o_wb.data;
            end
        end
    end

    // Avalon slave: answer on the second edge of a request
    assign bus_req = i_avs_read || i_avs_write;
    assign bus_done = bus_req && !o_avs_waitrequest;

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
        end else begin
            o_avs_waitrequest <= !(bus_req && o_avs_waitrequest);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            o_avs_readdata <= '0;
        end else if (i_avs_read && o_avs_waitrequest) begin
            unique case (i_avs_address)
                sbb_pkg::ADDR_CTRL: o_avs_readdata <= 32'(psr_carry_r);
                sbb_pkg::ADDR_OVF_CNT: o_avs_readdata <= 32'(ovf_cnt_r);
                sbb_pkg::ADDR_TARGET: o_avs_readdata <= last_tgt_r;
                sbb_pkg::ADDR_RESULT: o_avs_readdata <= last_res_r;
                default: o_avs_readdata <= '0;
            endcase
        end
    end

    // Assertion helpers: the issue of the previous cycle
    sbb_pkg::sbb_issue_t iq;
    logic [4:0] iq_off;
    logic carry_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_reset_n) begin
            iq <= '0;
            iq_off <= '0;
            carry_q <= 1'b0;
        end else begin
            iq <= i_issue;
            iq_off <= off;
            carry_q <= psr_carry_r;
        end
    end

    a_shift_arith:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_SPULL && iq.instr.imm_form
        && iq.instr.low[sbb_pkg::W_MSB:sbb_pkg::W_LSB] == 5'h00
        |-> o_wb.data == 32'($signed(iq.rs1_val) >>> iq.instr.low[4:0]))
        else $error("arithmetic shift result wrong");

    a_shift_logic:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_UPULL && !iq.instr.imm_form
        && iq.rs2_val[9:5] == 5'h00
        |-> o_wb.data == (iq.rs1_val >> iq.rs2_val[4:0]))
        else $error("logical shift result wrong");

    a_shift_left:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_INSERT && iq.instr.imm_form
        && iq.instr.low[9:5] == 5'h00
        |-> o_wb.data == (iq.rs1_val << iq.instr.low[4:0]))
        else $error("left shift result wrong");

    a_rotate_right:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_ROT
        |-> o_wb.data == ((iq.rs1_val >> iq_off)
        | (iq.rs1_val << (6'd32 - 6'(iq_off)))))
        else $error("rotate result wrong");

    a_rot_amount:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_ROT && !iq.instr.imm_form
        |-> iq_off == iq.rs2_val[4:0])
        else $error("rotate amount not from low five bits");

    a_delay_slot:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_br.valid |-> o_br.exec_next == $past(i_issue.instr.delay_flag)
        && (o_br.squash_next == (o_br.taken && !o_br.exec_next)))
        else $error("delay slot decode wrong");

    a_bit_zero:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_BIT_ZERO
        |-> o_br.valid && o_br.taken == !iq.rs1_val[iq.instr.dest_idx])
        else $error("bit zero branch decision wrong");

    a_bit_one:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_BIT_ONE
        |-> o_br.taken == iq.rs1_val[iq.instr.dest_idx])
        else $error("bit one branch decision wrong");

    a_branch_target:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_br.valid |-> o_br.target == iq.pc
        + {{14{iq.instr.low[15]}}, iq.instr.low, 2'b00})
        else $error("branch target wrong");

    a_add_sum:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_ADD && !iq.instr.imm_form
        |-> o_wb.data == iq.rs1_val + iq.rs2_val
        + 32'(iq.instr.low[9] && carry_q))
        else $error("add sum wrong");

    a_carry_hold:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        i_issue.valid && is_add && !cout_en && !(bus_done && i_avs_write)
        |=> psr_carry_r == $past(psr_carry_r))
        else $error("carry changed without carry out");

    a_overflow:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_wb.ovf |-> !o_wb.valid
        && iq.rs1_val[sbb_pkg::SIGN_BIT] != o_wb.data[sbb_pkg::SIGN_BIT])
        else $error("overflow flagged wrongly");

    a_ovf_raise:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_ADD && !iq.instr.imm_form
        && iq.rs1_val[sbb_pkg::SIGN_BIT] == iq.rs2_val[sbb_pkg::SIGN_BIT]
        && o_wb.data[sbb_pkg::SIGN_BIT] != iq.rs1_val[sbb_pkg::SIGN_BIT]
        |-> o_wb.ovf && !o_wb.valid)
        else $error("overflow not raised");

    a_carry_load:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        iq.valid && iq.instr.op == sbb_pkg::OP_ADD && !iq.instr.imm_form
        && iq.instr.low[sbb_pkg::COUT_BIT] && !o_wb.ovf
        |-> {o_carry, o_wb.data} == {1'b0, iq.rs1_val} + {1'b0, iq.rs2_val}
        + 33'(iq.instr.low[sbb_pkg::CIN_BIT] && carry_q))
        else $error("carry out not stored");

    a_zero_dest:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        o_wb.valid |-> o_wb.idx != 5'h00)
        else $error("zero register written");

    a_bus_answer:
    assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
        bus_req && o_avs_waitrequest |=> !o_avs_waitrequest ##1
        o_avs_waitrequest)
        else $error("bus answer timing wrong");

endmodule // sbb_unit

// ---- bench/sbb_decoder_model.sv ----
`timescale 1ns/1ps
module sbb_decoder_model (
    // Clock
    input wire logic i_clk_sys,
    // Issue to the unit
    output sbb_pkg::sbb_issue_t o_issue
);
    logic slot_r;

    initial begin
        o_issue = '0;
        slot_r = 1'b0;
    end

    // Issues one instruction for one cycle after a stall of gap cycles
    task automatic send(input logic [31:0] ins, input logic [31:0] a,
                        input logic [31:0] b, input logic [31:0] pc,
                        input int gap);
        if (ins[31:28] == 4'h4 && !ins[27]) b[9:5] = 5'h00;
        if (slot_r && ins[31:29] == 3'h3) ins[31:28] = 4'h0;
        slot_r = (ins[31:29] == 3'h3) && ins[26];
        repeat (gap) @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        o_issue.valid <= 1'b1;
        o_issue.instr <= ins;
        o_issue.rs1_val <= a;
        o_issue.rs2_val <= b;
        o_issue.pc <= pc;
        @(posedge i_clk_sys);
        o_issue.valid <= 1'b0;
        o_issue.rs1_val <= ~a;
        o_issue.rs2_val <= ~b;
    endtask
endmodule // sbb_decoder_model

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] adr = 4'h0;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic wait_rq;
    logic carry;
    logic c_exp = 1'b0;
    sbb_pkg::sbb_issue_t iss;
    sbb_pkg::sbb_wb_t wb;
    sbb_pkg::sbb_br_t br;
    int n_errors = 0;
    int comparisons = 0;

    always #10 clk = ~clk;

    sbb_decoder_model u_part (.i_clk_sys(clk), .o_issue(iss));

    sbb_unit dut (
        .i_clk_sys(clk), .i_reset_n(rst_n), .i_issue(iss),
        .o_wb(wb), .o_br(br), .o_carry(carry),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdat), .i_avs_byteenable(4'hF),
        .o_avs_readdata(rdat), .o_avs_waitrequest(wait_rq)
    );

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                     got, exp);
        end
    endtask

    function automatic logic [31:0] mk(input logic [3:0] op,
        input logic im, input logic dl, input logic [4:0] d,
        input logic [4:0] s, input logic [15:0] lo);
        return {op, im, dl, d, s, lo};
    endfunction

    task automatic run(input logic [31:0] ins, input logic [31:0] a,
                       input logic [31:0] b, input logic [31:0] pc,
                       input int gap);
        u_part.send(ins, a, b, pc, gap);
        @(negedge clk);
    endtask

    // Avalon transfer: held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wdat <= d;
        @(posedge clk);
        while (wait_rq !== 1'b0 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (n == 20) check(32'h1, 32'h0, "bus timeout");
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic t_shift();
        logic [3:0] op [6] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h4, 4'h2};
        logic [31:0] b [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF_FC1F,
            32'h0000_0004};
        logic [31:0] e [6] = '{32'hF800_000F, 32'h0800_000F,
            32'h0000_0F50, 32'h5800_000F, 32'h0000_01EB, 32'h0800_000F};
        for (int i = 0; i < 6; i++) begin
            run(mk(op[i], i < 4, 1'b0, 5'h09, 5'h01, 16'h0004),
                32'h8000_00F5, b[i], 32'h0, 0);
            check(wb.data, e[i], "shift data");
            check({27'h0, wb.idx}, 32'h9, "shift idx");
        end
        $display("test shift done");
    endtask

    task automatic t_add();
        logic [31:0] a [6] = '{32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h1, 32'h1,
            32'h0, 32'h7FFF_FFFF};
        logic [31:0] b [6] = '{32'h1, 32'h1, 32'h2, 32'h0, 32'h0, 32'h1};
        logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h3, 3'h1};
        logic [4:0] d [6] = '{5'h03, 5'h04, 5'h05, 5'h06, 5'h00, 5'h07};
        logic [32:0] s;
        logic [31:0] bb;
        logic ov;
        for (int i = 0; i < 6; i++) begin
            bb = m[i][2] ? 32'h0000_FF00 : b[i];
            s = {1'b0, a[i]} + {1'b0, bb}
                + {32'h0, m[i][1] & !m[i][2] & c_exp};
            ov = (a[i][31] == bb[31]) && (s[31] != a[i][31]);
            run(mk(4'h5, m[i][2], 1'b0, d[i], 5'h02, m[i][2] ? 16'hFF00
                : {6'h00, m[i][1:0], 8'h00}), a[i], b[i], 32'h0, 0);
            if (m[i][0] && !m[i][2] && !ov) c_exp = s[32];
            if (!ov && d[i] != 5'h00) check(wb.data, s[31:0], "sum");
            check({31'h0, wb.valid}, {31'h0, !ov && d[i] != 5'h00}, "wb");
            check({31'h0, wb.ovf}, {31'h0, ov}, "overflow");
            check({31'h0, carry}, {31'h0, c_exp}, "carry");
        end
        $display("test add done");
    endtask

    task automatic t_branch();
        logic [3:0] op [4] = '{4'h6, 4'h7, 4'h6, 4'h7};
        logic [4:0] bi [4] = '{5'h00, 5'h05, 5'h1F, 5'h1F};
        logic [31:0] a [4] = '{32'hFFFF_FFFE, 32'h0, 32'h8000_0000,
            32'h8000_0000};
        logic [15:0] ds [4] = '{16'hFFFF, 16'h0010, 16'h0001, 16'h7FFF};
        logic [31:0] pc [4] = '{32'h1000, 32'h2000, 32'h3000, 32'h0};
        logic tk;
        logic [31:0] tg;
        for (int i = 0; i < 4; i++) begin
            tk = a[i][bi[i]] == op[i][0];
            tg = pc[i] + {{14{ds[i][15]}}, ds[i], 2'b00};
            run(mk(op[i], 1'b0, i >= 2, bi[i], 5'h01, ds[i]), a[i], 32'h0,
                pc[i], i);
            check({31'h0, br.valid}, 32'h1, "br valid");
            check({31'h0, br.taken}, {31'h0, tk}, "taken");
            if (tk) check(br.target, tg, "target");
            check({31'h0, br.exec_next}, {31'h0, i >= 2}, "exec");
            check({31'h0, br.squash_next}, {31'h0, tk && i < 2}, "squash");
            run(32'h0, 32'h0, 32'h0, 32'h0, 0);
        end
        $display("test branch done");
    endtask

    task automatic t_bus();
        logic [31:0] r;
        bus(1'b1, 4'h0, 32'h1, r);
        c_exp = 1'b1;
        @(negedge clk);
        check({31'h0, carry}, 32'h1, "carry write");
        bus(1'b0, 4'h0, 32'h0, r);
        check(r, 32'h1, "ctrl read");
        bus(1'b0, 4'h4, 32'h0, r);
        check(r, 32'h1, "ovf count");
        bus(1'b1, 4'h8, 32'h1234_5678, r);
        bus(1'b0, 4'h8, 32'h0, r);
        check(r, 32'h0001_FFFC, "last target");
        bus(1'b0, 4'hC, 32'h0, r);
        check(r, 32'h0000_FF01, "last result");
        bus(1'b0, 4'h2, 32'h0, r);
        check(r, 32'h0, "unmapped");
        $display("test bus done");
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        #100000;
        n_errors++;
        close_out();
    end

    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        check({31'h0, wait_rq}, 32'h1, "idle waitrequest");
        check({31'h0, carry}, 32'h0, "reset carry");
        t_shift();
        t_add();
        t_branch();
        t_bus();
        close_out();
    end
endmodule // tb
